// ### logic/ccd_exec.sv
// execution unit for call, watchdog kick, clears, invert, decrements
// assumes an axi4-lite master on the core clock issues instructions
`timescale 1ns/1ps
`default_nettype none
`include "ccd_cfg.svh"
module ccd_exec #(
  parameter int STACK_DEPTH = 8,                // return stack entries
  parameter int TCY_CLKS    = `CCD_TCY_CLKS     // clocks per instr cycle
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] axi_awaddr_in,
  input  wire logic        axi_awvalid_in,
  output logic             axi_awready_out,
  input  wire logic [31:0] axi_wdata_in,
  input  wire logic [3:0]  axi_wstrb_in,
  input  wire logic        axi_wvalid_in,
  output logic             axi_wready_out,
  output logic [1:0]       axi_bresp_out,
  output logic             axi_bvalid_out,
  input  wire logic        axi_bready_in,
  input  wire logic [11:0] axi_araddr_in,
  input  wire logic        axi_arvalid_in,
  output logic             axi_arready_out,
  output logic [31:0]      axi_rdata_out,
  output logic [1:0]       axi_rresp_out,
  output logic             axi_rvalid_out,
  input  wire logic        axi_rready_in,
  output logic [12:0]      pc_out,
  output logic             busy_out
);
  localparam int SPW = $clog2(STACK_DEPTH);
  ccd_pkg::ccd_state_t state;          // sequencing state
  ccd_pkg::ccd_pc_t    pc;             // program counter
  ccd_pkg::ccd_pc_t    stk [STACK_DEPTH]; // return stack
  logic [SPW-1:0]      sp;             // stack head index
  logic [7:0]          fmem [128];     // file registers
  logic [13:0]         ir;             // instruction in flight
  logic [7:0]          acc;            // accumulator
  logic [2:0]          stat;           // zero, power-down, expiry
  logic [4:0]          latch;          // upper program counter latch
  logic [7:0]          wd_cnt;         // watchdog counter
  logic [7:0]          wd_pre;         // watchdog prescaler
  logic [7:0]          cyc;            // instruction cycle divider
  logic                tick;           // one pulse per instr cycle
  logic                skip;           // skip owed by tail cycle
  logic                bad_op;         // last opcode was unknown
  // bus capture
  logic                aw_held;        // write address held
  logic                w_held;         // write data held
  logic [11:0]         aw_q;           // held write address
  logic [31:0]         wd_q;           // held write data
  logic [3:0]          ws_q;           // held strobes
  logic                do_wr;          // write performed now
  logic                sw_ok;          // state writes allowed now
  logic [31:0]         rd_val;         // read mux value
  logic                rd_hit;         // read address mapped
  logic                wr_hit;         // write address mapped
  // decode
  logic                exec;           // first cycle executes now
  logic [5:0]          opc;            // operation field
  logic                dst;            // destination select
  logic [6:0]          fidx;           // file address
  logic [7:0]          fval;           // addressed file value
  logic [7:0]          res;            // operation result
  logic                to_acc;         // result goes to accumulator
  logic                to_file;        // result goes to file
  logic                z_upd;          // zero flag updated
  logic                two_cyc;        // needs a tail cycle
  logic                kick;           // watchdog kick
  logic                is_call;        // subroutine jump
  logic                known;          // opcode recognised
  logic [31:0]         wmerge;         // held data merged by strobes
  logic [31:0]         wold;           // old value under write
  // byte-lane merge of a write onto an old value
  function automatic logic [31:0] ccd_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction : ccd_merge
  // instruction cycle divider
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cyc <= 8'h00;
    end else if (tick) begin
      cyc <= 8'h00;
    end else begin
      cyc <= cyc + 8'h01;
    end
  end
  assign tick = (cyc == 8'(TCY_CLKS - 1));
  // operand fields
  assign is_call = (ir[13:11] == `CCD_OP_CALL);
  assign opc     = ir[13:8];
  assign dst     = ir[7];
  assign fidx    = ir[6:0];
  assign fval    = fmem[fidx];
  assign exec    = (state == ccd_pkg::CCD_WAIT) && tick;
  // result, routing and flag effects
  always_comb begin
    res     = 8'h00;
    to_acc  = 1'b0;
    to_file = 1'b0;
    z_upd   = 1'b0;
    two_cyc = 1'b0;
    kick    = 1'b0;
    known   = 1'b1;
    if (is_call) begin
      two_cyc = 1'b1;
    end else begin
      case (opc)
        `CCD_OP_NOP: res = 8'h00;                           // no effect
        `CCD_OP_FZERO: begin
          to_file = 1'b1;
          z_upd   = 1'b1;
        end
        `CCD_OP_AZERO: begin
          to_acc = 1'b1;
          z_upd  = 1'b1;
        end
        `CCD_OP_INV: begin
          res     = ~fval;
          to_acc  = !dst;
          to_file = dst;
          z_upd   = 1'b1;
        end
        `CCD_OP_DEC: begin
          res     = fval - 8'h01;
          to_acc  = !dst;
          to_file = dst;
          z_upd   = 1'b1;
        end
        `CCD_OP_DECSZ: begin
          res     = fval - 8'h01;
          to_acc  = !dst;
          to_file = dst;
          two_cyc = (res == 8'h00);
        end
        `CCD_OP_KICK: kick = 1'b1;
        default: known = 1'b0;                              // treated as nop
      endcase
    end
  end
  // sequencing: issue, first cycle, tail cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state <= ccd_pkg::CCD_IDLE;
      ir    <= 14'h0000;
      skip  <= 1'b0;
    end else begin
      case (state)
        ccd_pkg::CCD_IDLE: begin
          if (do_wr && aw_q == `CCD_A_INSTR) begin
            ir    <= wmerge[13:0];
            state <= ccd_pkg::CCD_WAIT;
          end
        end
        ccd_pkg::CCD_WAIT: begin
          if (tick) begin
            skip  <= two_cyc && !is_call;
            state <= two_cyc ? ccd_pkg::CCD_TAIL : ccd_pkg::CCD_IDLE;
          end
        end
        ccd_pkg::CCD_TAIL: begin
          if (tick) begin
            skip  <= 1'b0;
            state <= ccd_pkg::CCD_IDLE;
          end
        end
        default: state <= ccd_pkg::CCD_IDLE;
      endcase
    end
  end
  assign busy_out = (state != ccd_pkg::CCD_IDLE);
  assign sw_ok    = (state == ccd_pkg::CCD_IDLE);
  // program counter
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pc <= `CCD_PC_RST;
    end else if (exec && is_call) begin
      pc <= {latch[4:3], ir[10:0]};
    end else if (exec) begin
      pc <= pc + 13'h0001;
    end else if (state == ccd_pkg::CCD_TAIL && tick && skip) begin
      pc <= pc + 13'h0001;
    end else if (do_wr && sw_ok && aw_q == `CCD_A_PC) begin
      pc <= wmerge[12:0];
    end
  end
  assign pc_out = pc;
  // return stack, head advances on each call
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sp <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk[i] <= 13'h0000;
      end
    end else if (exec && is_call) begin
      sp          <= sp + 1'b1;
      stk[sp + 1'b1] <= pc + 13'h0001;
    end
  end
  // accumulator
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      acc <= 8'h00;
    end else if (exec && to_acc) begin
      acc <= res;
    end else if (do_wr && sw_ok && aw_q == `CCD_A_ACC) begin
      acc <= wmerge[7:0];
    end
  end
  // file registers, no reset
  always_ff @(posedge core_clk_in) begin
    if (exec && to_file) begin
      fmem[fidx] <= res;
    end else if (do_wr && sw_ok && aw_q[11:9] == `CCD_A_FILE_HI) begin
      fmem[aw_q[8:2]] <= wmerge[7:0];
    end
  end
  // status flags; call and skip ops leave them alone
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stat   <= `CCD_STAT_RST;
      bad_op <= 1'b0;
    end else if (exec) begin
      bad_op <= !known;
      if (z_upd) begin
        stat[`CCD_ST_Z] <= (res == 8'h00);
      end
      if (kick) begin
        stat[`CCD_ST_TO] <= 1'b1;
        stat[`CCD_ST_PD] <= 1'b1;
      end
    end else if (do_wr && sw_ok && aw_q == `CCD_A_STAT) begin
      stat <= wmerge[2:0];
    end
  end
  // upper program counter latch
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      latch <= 5'h00;
    end else if (do_wr && sw_ok && aw_q == `CCD_A_LATCH) begin
      latch <= wmerge[4:0];
    end
  end
  // watchdog prescaler advanced once per instr cycle, counter once per 256 instr cycles
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wd_pre <= 8'h00;
      wd_cnt <= 8'h00;
    end else if (exec && kick) begin
      wd_pre <= 8'h00;
      wd_cnt <= 8'h00;
    end else if (tick) begin
      wd_pre <= wd_pre + 8'h01;
      if (wd_pre == 8'hff) begin
        wd_cnt <= wd_cnt + 8'h01;
      end
    end
  end
  // write channel capture, either order
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 12'h000;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end else if (do_wr) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (axi_awvalid_in && axi_awready_out) begin
        aw_held <= 1'b1;
        aw_q    <= {axi_awaddr_in[11:2], 2'h0};
      end
      if (axi_wvalid_in && axi_wready_out) begin
        w_held <= 1'b1;
        wd_q   <= axi_wdata_in;
        ws_q   <= axi_wstrb_in;
      end
    end
  end
  assign axi_awready_out = !aw_held && !axi_bvalid_out;
  assign axi_wready_out  = !w_held && !axi_bvalid_out;
  assign do_wr           = aw_held && w_held && !axi_bvalid_out;
  // writable map and old value for merging
  always_comb begin
    wr_hit = 1'b1;
    wold   = 32'h0000_0000;
    if (aw_q == `CCD_A_INSTR) begin
      wold = {18'h00000, ir};
    end else if (aw_q == `CCD_A_PC) begin
      wold = {19'h00000, pc};
    end else if (aw_q == `CCD_A_ACC) begin
      wold = {24'h000000, acc};
    end else if (aw_q == `CCD_A_STAT) begin
      wold = {29'h00000000, stat};
    end else if (aw_q == `CCD_A_LATCH) begin
      wold = {27'h0000000, latch};
    end else if (aw_q[11:9] == `CCD_A_FILE_HI) begin
      wold = {24'h000000, fmem[aw_q[8:2]]};
    end else begin
      wr_hit = 1'b0;
    end
  end
  assign wmerge = ccd_merge(wold, wd_q, ws_q);
  // write response
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      axi_bvalid_out <= 1'b0;
      axi_bresp_out  <= `CCD_RESP_OK;
    end else if (do_wr) begin
      axi_bvalid_out <= 1'b1;
      axi_bresp_out  <= wr_hit ? `CCD_RESP_OK : `CCD_RESP_ERR;
    end else if (axi_bready_in) begin
      axi_bvalid_out <= 1'b0;
    end
  end
  // read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (axi_araddr_in[11:2] == `CCD_A_INSTR >> 2) begin
      rd_val = {18'h00000, ir};
    end else if (axi_araddr_in[11:2] == `CCD_A_PC >> 2) begin
      rd_val = {19'h00000, pc};
    end else if (axi_araddr_in[11:2] == `CCD_A_ACC >> 2) begin
      rd_val = {24'h000000, acc};
    end else if (axi_araddr_in[11:2] == `CCD_A_STAT >> 2) begin
      rd_val = {29'h00000000, stat};
    end else if (axi_araddr_in[11:2] == `CCD_A_LATCH >> 2) begin
      rd_val = {27'h0000000, latch};
    end else if (axi_araddr_in[11:2] == `CCD_A_STACK >> 2) begin
      rd_val = {19'h00000, stk[sp]};
    end else if (axi_araddr_in[11:2] == `CCD_A_WDOG >> 2) begin
      rd_val = {16'h0000, wd_pre, wd_cnt};
    end else if (axi_araddr_in[11:2] == `CCD_A_STATE >> 2) begin
      rd_val = {29'h00000000, bad_op, skip, busy_out};
    end else if (axi_araddr_in[11:9] == `CCD_A_FILE_HI) begin
      rd_val = {24'h000000, fmem[axi_araddr_in[8:2]]};
    end else begin
      rd_hit = 1'b0;
    end
  end
  // read response
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      axi_rvalid_out <= 1'b0;
      axi_rdata_out  <= 32'h0000_0000;
      axi_rresp_out  <= `CCD_RESP_OK;
    end else if (axi_arvalid_in && axi_arready_out) begin
      axi_rvalid_out <= 1'b1;
      axi_rdata_out  <= rd_val;
      axi_rresp_out  <= rd_hit ? `CCD_RESP_OK : `CCD_RESP_ERR;
    end else if (axi_rready_in) begin
      axi_rvalid_out <= 1'b0;
    end
  end
  assign axi_arready_out = !axi_rvalid_out;
endmodule : ccd_exec
`default_nettype wire

// ### logic/ccd_cfg.svh
// constants for the call/clear/decrement execution unit
// assumes one 250 MHz core clock and a 32-bit register bus
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH
// register byte offsets
`define CCD_A_INSTR   12'h000
`define CCD_A_PC      12'h004
`define CCD_A_ACC     12'h008
`define CCD_A_STAT    12'h00c
`define CCD_A_LATCH   12'h010
`define CCD_A_STACK   12'h014
`define CCD_A_WDOG    12'h018
`define CCD_A_STATE   12'h01c
`define CCD_A_FILE_HI 3'h1
// status field positions and reset values
`define CCD_ST_Z      0
`define CCD_ST_PD     1
`define CCD_ST_TO     2
`define CCD_STAT_RST  3'h6
`define CCD_PC_RST    13'h0000
// instruction encoding
`define CCD_OP_CALL   3'h4
`define CCD_OP_NOP    6'h00
`define CCD_OP_FZERO  6'h01
`define CCD_OP_AZERO  6'h02
`define CCD_OP_INV    6'h03
`define CCD_OP_DEC    6'h04
`define CCD_OP_DECSZ  6'h05
`define CCD_OP_KICK   6'h06
// timing
`define CCD_CLK_MHZ   250
`define CCD_TCY_NS    16
`define CCD_TCY_CLKS  ((`CCD_TCY_NS * `CCD_CLK_MHZ) / 1000)
`define CCD_RESP_OK   2'h0
`define CCD_RESP_ERR  2'h2
`endif

// ### logic/ccd_pkg.sv
// types shared by the execution unit
// assumes ccd_cfg.svh supplies the numbers
package ccd_pkg;
  // instruction sequencing states
  typedef enum logic [1:0] {CCD_IDLE, CCD_WAIT, CCD_TAIL} ccd_state_t;
  typedef logic [12:0] ccd_pc_t;  // program counter word
endpackage : ccd_pkg

// ### test/ccd_exec_checker.sv
// checker for bus handshakes and busy timing of the execution unit
// assumes it is bound to ccd_exec and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ccd_exec_checker (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        axi_awready_out,
  input wire logic        axi_wready_out,
  input wire logic        axi_bvalid_out,
  input wire logic [1:0]  axi_bresp_out,
  input wire logic        axi_bready_in,
  input wire logic        axi_arvalid_in,
  input wire logic        axi_arready_out,
  input wire logic        axi_rvalid_out,
  input wire logic [31:0] axi_rdata_out,
  input wire logic        axi_rready_in,
  input wire logic        busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // write answer holds until taken
  property p_b_hold;
    axi_bvalid_out && !axi_bready_in |=> axi_bvalid_out && $stable(axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  // no new write while answer pending
  property p_aw_block;
    axi_bvalid_out |-> !axi_awready_out && !axi_wready_out;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during answer");
  // read address refused while data pending
  property p_ar_block;
    axi_rvalid_out |-> !axi_arready_out;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
  // read data one cycle after address
  property p_r_lat;
    axi_arvalid_in && axi_arready_out |=> axi_rvalid_out;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  // read data holds until taken
  property p_r_hold;
    axi_rvalid_out && !axi_rready_in |=> axi_rvalid_out && $stable(axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed");
  // write response codes are okay or slave error only
  property p_resp;
    axi_bvalid_out |-> axi_bresp_out == 2'h0 || axi_bresp_out == 2'h2;
  endproperty
  a_resp: assert property (p_resp) else $error("bad write response code");
  // an instruction starts only with its write answer
  property p_busy_start;
    $rose(busy_out) |-> $rose(axi_bvalid_out);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without issue");
  // at most two instruction cycles of four clocks
  property p_busy_bound;
    $rose(busy_out) |-> ##[1:9] !busy_out;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
endmodule : ccd_exec_checker
bind ccd_exec ccd_exec_checker u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .axi_awready_out(axi_awready_out), .axi_wready_out(axi_wready_out),
  .axi_bvalid_out(axi_bvalid_out), .axi_bresp_out(axi_bresp_out),
  .axi_bready_in(axi_bready_in), .axi_arvalid_in(axi_arvalid_in),
  .axi_arready_out(axi_arready_out), .axi_rvalid_out(axi_rvalid_out),
  .axi_rdata_out(axi_rdata_out), .axi_rready_in(axi_rready_in), .busy_out(busy_out));
`default_nettype wire

// ### test/tb_call_clear_decrement_exec.sv
// self-checking bench for the execution unit, random operands
// assumes ccd_exec, its checker and ccd_cfg.svh are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ccd_cfg.svh"
module tb_call_clear_decrement_exec;
  logic        clk, rst_n;                      // clock and reset
  logic [11:0] awaddr, araddr;                  // bus addresses
  logic [31:0] wdata, rdata, dv;                // bus data
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]  bresp, rresp, rs;                // response codes
  logic [12:0] pc, p0;                          // pc seen, pc preset
  logic [7:0]  v, a0, ea, ef;                   // operands and expectations
  logic [5:0]  op;                              // opcode under test
  logic [6:0]  f;                               // file address
  logic [2:0]  s0, es;                          // status preset, expected
  logic [10:0] k;                               // call target
  logic [4:0]  lt;                              // latch preset
  logic        d, sk;                           // destination, skip expected
  int          fail_count, total_checks, n_busy;
  ccd_exec uut (.core_clk_in(clk), .rst_n_in(rst_n), .axi_awaddr_in(awaddr),
    .axi_awvalid_in(awvalid), .axi_awready_out(awready), .axi_wdata_in(wdata),
    .axi_wstrb_in(4'hf), .axi_wvalid_in(wvalid), .axi_wready_out(wready),
    .axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
    .axi_araddr_in(araddr), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
    .axi_rready_in(rready), .pc_out(pc), .busy_out(busy));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // one write, each channel released at the edge it is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dd, output logic [1:0] r);
    bit aw_t, w_t, b_t;
    b_t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // wait for the answer; only the hang guard ends a stuck wait
    while (!b_t) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr
  // one read, data taken at the edge rvalid is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] r);
    bit a_t, r_t;
    r_t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // wait for the answer; only the hang guard ends a stuck wait
    while (!r_t) begin
      @(negedge clk);
      a_t = arvalid && arready;
      r_t = rvalid;
      dd = rdata;
      r = rresp;
      @(posedge clk);
      if (a_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd
  // write expecting okay
  task automatic wo(input logic [11:0] a, input logic [31:0] dd);
    logic [1:0] r;
    wr(a, dd, r);
    chk({30'h0, r}, 32'h0, "write response");
  endtask : wo
  // read and compare with okay response
  task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] dd;
    logic [1:0]  r;
    rd(a, dd, r);
    chk({30'h0, r}, 32'h0, "read response");
    chk(dd, exp, what);
  endtask : rc
  // issue one instruction and wait until idle
  task automatic exec(input logic [13:0] ir);
    int n;
    n = 0;
    n_busy = 0;
    wo(`CCD_A_INSTR, {18'h0, ir});
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (busy !== 1'b0) chk(0, 1, "busy stuck");
  endtask : exec
  // expected results of the single-operand instructions
  function automatic void predict(input logic [5:0] o, input logic dst, input logic [7:0] fv,
      input logic [7:0] av, input logic [2:0] sv, output logic [7:0] xa,
      output logic [7:0] xf, output logic [2:0] xs, output logic xk);
    logic [7:0] res;
    res = (o == `CCD_OP_INV) ? ~fv : fv - 8'h01;
    xa = av;
    xf = fv;
    xs = sv;
    xk = 1'b0;
    if (o == `CCD_OP_FZERO) xf = 8'h00;
    else if (o == `CCD_OP_AZERO) xa = 8'h00;
    else if (dst) xf = res;
    else xa = res;
    if (o == `CCD_OP_FZERO || o == `CCD_OP_AZERO) xs[`CCD_ST_Z] = 1'b1;
    else if (o != `CCD_OP_DECSZ) xs[`CCD_ST_Z] = (res == 8'h00);
    else xk = (res == 8'h00);
  endfunction : predict
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // busy cycle counter
  always @(negedge clk) begin
    if (busy === 1'b1) n_busy++;
  end
  // hang guard
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  // main sequence
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    rst_n = 1'b0;
    void'($urandom(32'hb3ce));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rc(`CCD_A_PC, 32'h0, "pc reset");
    rc(`CCD_A_STAT, {29'h0, `CCD_STAT_RST}, "status reset");
    rd(12'h100, dv, rs);
    chk({30'h0, rs}, 32'h2, "unmapped read");
    wr(`CCD_A_STACK, 32'h1, rs);
    chk({30'h0, rs}, 32'h2, "read-only write");
    // clears, invert and decrements with corner operands
    for (int i = 0; i < 40; i++) begin
      op = 6'h01 + 6'(i % 5);
      f = (i == 3) ? 7'h7f : 7'($urandom);
      d = 1'($urandom);
      v = (i % 4 == 0) ? 8'h01 : (i % 4 == 1) ? 8'h00 : 8'($urandom);
      a0 = 8'($urandom);
      p0 = (i == 5) ? 13'h1fff : 13'($urandom);
      s0 = 3'($urandom);
      wo({`CCD_A_FILE_HI, f, 2'h0}, {24'h0, v});
      wo(`CCD_A_ACC, {24'h0, a0});
      wo(`CCD_A_PC, {19'h0, p0});
      wo(`CCD_A_STAT, {29'h0, s0});
      exec({op, d, f});
      predict(op, d, v, a0, s0, ea, ef, es, sk);
      rc(`CCD_A_ACC, {24'h0, ea}, "acc");
      rc({`CCD_A_FILE_HI, f, 2'h0}, {24'h0, ef}, "file");
      rc(`CCD_A_STAT, {29'h0, es}, "status");
      rc(`CCD_A_PC, {19'h0, p0 + 13'h1 + 13'(sk)}, "pc");
      chk(32'(n_busy > 4), 32'(sk), "cycles");
    end
    // subroutine calls
    for (int i = 0; i < 8; i++) begin
      k = (i == 0) ? 11'h7ff : 11'($urandom);
      lt = 5'($urandom);
      p0 = 13'($urandom);
      s0 = 3'($urandom);
      wo(`CCD_A_LATCH, {27'h0, lt});
      wo(`CCD_A_PC, {19'h0, p0});
      wo(`CCD_A_STAT, {29'h0, s0});
      exec({`CCD_OP_CALL, k});
      rc(`CCD_A_PC, {19'h0, lt[4:3], k}, "call pc");
      rc(`CCD_A_STACK, {19'h0, p0 + 13'h1}, "call stack");
      rc(`CCD_A_STAT, {29'h0, s0}, "call status");
      chk(32'(n_busy > 4), 32'h1, "call cycles");
    end
    // no-operation and an unknown opcode advance pc and keep acc; only the unknown one sets the flag
    for (int i = 0; i < 2; i++) begin
      op = (i == 0) ? `CCD_OP_NOP : 6'h3f;
      a0 = 8'($urandom);
      p0 = 13'($urandom);
      wo(`CCD_A_ACC, {24'h0, a0});
      wo(`CCD_A_PC, {19'h0, p0});
      exec({op, 8'h00});
      rc(`CCD_A_PC, {19'h0, p0 + 13'h1}, "nop pc");
      rc(`CCD_A_ACC, {24'h0, a0}, "nop acc");
      rc(`CCD_A_STATE, {29'h0, 1'(i), 2'h0}, "unknown opcode flag");
      chk(32'(n_busy > 4), 32'h0, "nop cycles");
    end
    // watchdog kick after the counter has advanced, zero flag kept
    wo(`CCD_A_STAT, 32'h1);
    repeat (1100) @(posedge clk);
    rd(`CCD_A_WDOG, dv, rs);
    chk(32'(dv[7:0] != 8'h00), 32'h1, "watchdog not advancing");
    exec({`CCD_OP_KICK, 8'h00});
    chk(32'(n_busy > 4), 32'h0, "kick cycles");
    rd(`CCD_A_WDOG, dv, rs);
    chk({30'h0, rs}, 32'h0, "watchdog read response");
    chk({24'h0, dv[7:0]}, 32'h0, "watchdog counter");
    chk(32'(dv[15:8] < 8'h08), 32'h1, "watchdog prescaler");
    rc(`CCD_A_STAT, 32'h7, "kick status");
    close_out();
  end
endmodule : tb_call_clear_decrement_exec
`default_nettype wire
